/* logic/sef_error_flags.sv */
// error flag logic: receiver overrun and transmit bit error flags with registers
`timescale 1ns/1ps

module sef_error_flags (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input sef_pkg::sef_bus_req_type req_i,
  input wire logic xfer_active_i,
  input wire logic xfer_done_i,
  input wire logic tx_bit_i,
  input wire logic link_clk_i,
  input wire logic tx_line_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic module_enable_o
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  sef_pkg::sef_link_type link;   // synchronised edges and transmit level

  // both pins go through the same two flops so they stay aligned
  sef_link_sampler u_sampler (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .link_clk_i(link_clk_i),
    .tx_line_i(tx_line_i),
    .link_o(link)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the request is a write to the given offset
  function automatic logic wr_hit(input sef_pkg::sef_bus_req_type r, input logic [7:0] off);
    wr_hit = r.wr & (r.addr == off);
  endfunction : wr_hit

  // true when the request is a read of the given offset
  function automatic logic rd_hit(input sef_pkg::sef_bus_req_type r, input logic [7:0] off);
    rd_hit = r.rd & (r.addr == off);
  endfunction : rd_hit

  // ----------------------------------------------------------------
  // decoded accesses
  // ----------------------------------------------------------------
  logic wr_gcr1;       // write to global_control_1
  logic wr_inten;      // write to interrupt_enable_reg
  logic wr_flags;      // write to error_status_flags
  logic rd_flags;      // read of error_status_flags
  logic rd_buffer;     // read of receive_buffer_reg
  logic rd_vector;     // read of either vector register

  always_comb begin
    wr_gcr1 = wr_hit(req_i, sef_pkg::OFF_GLOBAL_CONTROL_1);
    wr_inten = wr_hit(req_i, sef_pkg::OFF_INTERRUPT_ENABLE);
    wr_flags = wr_hit(req_i, sef_pkg::OFF_ERROR_STATUS_FLAGS);
    rd_flags = rd_hit(req_i, sef_pkg::OFF_ERROR_STATUS_FLAGS);
    rd_buffer = rd_hit(req_i, sef_pkg::OFF_RECEIVE_BUFFER);
    rd_vector = rd_hit(req_i, sef_pkg::OFF_VECTOR_0) | rd_hit(req_i, sef_pkg::OFF_VECTOR_1);
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic module_enable_r;       // module_enable in global_control_1
  logic rx_on_fall_r;          // receive point on falling serial clock edge
  logic overrun_int_en_r;      // overrun interrupt enable
  logic bit_error_int_enable_r; // bit error interrupt enable
  logic module_enable_nxt;
  logic rx_on_fall_nxt;
  logic overrun_int_en_nxt;
  logic bit_error_int_enable_nxt;
  logic disable_evt;           // module_enable written to zero

  // plain storage; the enable write also feeds the flag clears
  always_comb begin
    module_enable_nxt = module_enable_r;
    rx_on_fall_nxt = rx_on_fall_r;
    overrun_int_en_nxt = overrun_int_en_r;
    bit_error_int_enable_nxt = bit_error_int_enable_r;
    disable_evt = 1'b0;
    if (wr_gcr1) begin
      module_enable_nxt = req_i.wdata[sef_pkg::POS_MODULE_ENABLE];
      rx_on_fall_nxt = req_i.wdata[sef_pkg::POS_RX_ON_FALL];
      disable_evt = ~req_i.wdata[sef_pkg::POS_MODULE_ENABLE];
    end
    if (wr_inten) begin
      overrun_int_en_nxt = req_i.wdata[sef_pkg::POS_OVERRUN];
      bit_error_int_enable_nxt = req_i.wdata[sef_pkg::POS_BIT_ERROR];
    end
  end

  // register the control state
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      module_enable_r <= sef_pkg::RST_CTRL;
      rx_on_fall_r <= sef_pkg::RST_CTRL;
      overrun_int_en_r <= sef_pkg::RST_CTRL;
      bit_error_int_enable_r <= sef_pkg::RST_CTRL;
    end else begin
      module_enable_r <= module_enable_nxt;
      rx_on_fall_r <= rx_on_fall_nxt;
      overrun_int_en_r <= overrun_int_en_nxt;
      bit_error_int_enable_r <= bit_error_int_enable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bit error detection on the serial clock edges
  // ----------------------------------------------------------------
  logic tx_hold_r;      // bit that was driven at the last transmit point
  logic tx_seen_r;      // a transmit point has passed in this frame
  logic tx_hold_nxt;
  logic tx_seen_nxt;
  logic tx_point;       // transmit edge of the serial clock
  logic rx_point;       // receive edge, half a serial clock later
  logic mismatch_evt;   // sampled transmit line differs from driven bit

  // the transmit point is the edge opposite the receive point
  always_comb begin
    tx_point = rx_on_fall_r ? link.clk_rise : link.clk_fall;
    rx_point = rx_on_fall_r ? link.clk_fall : link.clk_rise;
    tx_hold_nxt = tx_hold_r;
    tx_seen_nxt = tx_seen_r;
    if (!xfer_active_i || !module_enable_r) begin
      // no frame: forget the held bit so a stray edge cannot compare
      tx_seen_nxt = 1'b0;
    end else if (tx_point) begin
      tx_hold_nxt = tx_bit_i;
      tx_seen_nxt = 1'b1;
    end
    // compare the line level at the receive point with the held bit
    mismatch_evt = module_enable_r & xfer_active_i & tx_seen_r & rx_point
                   & (link.tx_level != tx_hold_r);
  end

  // register the held transmit bit
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      tx_hold_r <= 1'b0;
      tx_seen_r <= 1'b0;
    end else begin
      tx_hold_r <= tx_hold_nxt;
      tx_seen_r <= tx_seen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic overrun_flag_r;        // overrun_flag
  logic bit_error_flag_r;      // bit_error_flag
  logic buffer_bit_error_r;    // buffer_bit_error indicator
  logic unread_r;              // received character not yet read
  logic overrun_flag_nxt;
  logic bit_error_flag_nxt;
  logic buffer_bit_error_nxt;
  logic unread_nxt;
  logic done_evt;              // transfer completed while enabled

  // clears are applied first so a same-cycle set always wins
  always_comb begin
    done_evt = xfer_done_i & module_enable_r;
    overrun_flag_nxt = overrun_flag_r;
    bit_error_flag_nxt = bit_error_flag_r;
    buffer_bit_error_nxt = buffer_bit_error_r;
    unread_nxt = unread_r;
    // overrun clears: vector read, write one, module disable
    if (rd_vector) begin
      overrun_flag_nxt = 1'b0;
    end
    if (wr_flags && req_i.wdata[sef_pkg::POS_OVERRUN]) begin
      overrun_flag_nxt = 1'b0;
    end
    if (disable_evt) begin
      overrun_flag_nxt = 1'b0;
    end
    // bit error flag is cleared by reading it; writes do nothing
    if (rd_flags) begin
      bit_error_flag_nxt = 1'b0;
    end
    // a buffer read consumes the character and its indicator only
    if (rd_buffer) begin
      unread_nxt = 1'b0;
      buffer_bit_error_nxt = 1'b0;
    end
    if (disable_evt) begin
      unread_nxt = 1'b0;
      buffer_bit_error_nxt = 1'b0;
    end
    // sets
    if (done_evt) begin
      unread_nxt = 1'b1;
      if (unread_r && !rd_buffer) begin
        overrun_flag_nxt = 1'b1;
      end
    end
    if (mismatch_evt) begin
      bit_error_flag_nxt = 1'b1;
      buffer_bit_error_nxt = 1'b1;
    end
  end

  // register the flags
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      overrun_flag_r <= sef_pkg::RST_FLAG;
      bit_error_flag_r <= sef_pkg::RST_FLAG;
      buffer_bit_error_r <= sef_pkg::RST_FLAG;
      unread_r <= sef_pkg::RST_FLAG;
    end else begin
      overrun_flag_r <= overrun_flag_nxt;
      bit_error_flag_r <= bit_error_flag_nxt;
      buffer_bit_error_r <= buffer_bit_error_nxt;
      unread_r <= unread_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data and interrupt
  // ----------------------------------------------------------------
  logic [31:0] rdata_r;
  logic irq_r;
  logic [31:0] rdata_nxt;
  logic irq_nxt;

  // read data shows the value before any read side effect lands
  always_comb begin
    rdata_nxt = sef_pkg::RST_RDATA;
    if (req_i.rd) begin
      case (req_i.addr)
        sef_pkg::OFF_GLOBAL_CONTROL_1: begin
          rdata_nxt[sef_pkg::POS_MODULE_ENABLE] = module_enable_r;
          rdata_nxt[sef_pkg::POS_RX_ON_FALL] = rx_on_fall_r;
        end
        sef_pkg::OFF_INTERRUPT_ENABLE: begin
          rdata_nxt[sef_pkg::POS_OVERRUN] = overrun_int_en_r;
          rdata_nxt[sef_pkg::POS_BIT_ERROR] = bit_error_int_enable_r;
        end
        sef_pkg::OFF_ERROR_STATUS_FLAGS: begin
          // only two flag bits exist; all others read zero
          rdata_nxt[sef_pkg::POS_OVERRUN] = overrun_flag_r;
          rdata_nxt[sef_pkg::POS_BIT_ERROR] = bit_error_flag_r;
        end
        sef_pkg::OFF_RECEIVE_BUFFER: begin
          rdata_nxt[sef_pkg::POS_BUF_BIT_ERROR] = buffer_bit_error_r;
          rdata_nxt[sef_pkg::POS_BUF_UNREAD] = unread_r;
        end
        sef_pkg::OFF_VECTOR_0, sef_pkg::OFF_VECTOR_1: begin
          rdata_nxt[sef_pkg::POS_VEC_OVERRUN] = overrun_flag_r & overrun_int_en_r;
          rdata_nxt[sef_pkg::POS_VEC_BIT_ERROR] = buffer_bit_error_r & bit_error_int_enable_r;
        end
        default: begin
          // unmapped addresses read as zero
          rdata_nxt = sef_pkg::RST_RDATA;
        end
      endcase
    end
    // level interrupt follows the flag state of the next cycle
    irq_nxt = (overrun_flag_nxt & overrun_int_en_nxt)
              | (buffer_bit_error_nxt & bit_error_int_enable_nxt);
  end

  // register the outputs so they come straight from flops
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_r <= sef_pkg::RST_RDATA;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o = irq_r;
  assign module_enable_o = module_enable_r;

endmodule : sef_error_flags

/* logic/sef_pkg.sv */
// package for the spi error flag block: register map, field positions, carrier types
package sef_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_GLOBAL_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFF_INTERRUPT_ENABLE = 8'h08;
  localparam logic [7:0] OFF_ERROR_STATUS_FLAGS = 8'h10;
  localparam logic [7:0] OFF_RECEIVE_BUFFER = 8'h40;
  localparam logic [7:0] OFF_VECTOR_0 = 8'h60;
  localparam logic [7:0] OFF_VECTOR_1 = 8'h64;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned POS_MODULE_ENABLE = 0;   // global_control_1
  localparam int unsigned POS_RX_ON_FALL = 1;      // global_control_1: receive point edge
  localparam int unsigned POS_OVERRUN = 6;         // flags and interrupt enable
  localparam int unsigned POS_BIT_ERROR = 4;       // flags and interrupt enable
  localparam int unsigned POS_BUF_BIT_ERROR = 12;  // receive_buffer_reg
  localparam int unsigned POS_BUF_UNREAD = 31;     // receive_buffer_reg
  localparam int unsigned POS_VEC_OVERRUN = 1;     // vector registers
  localparam int unsigned POS_VEC_BIT_ERROR = 0;   // vector registers

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_CTRL = 1'b0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // one register bus request, all fields valid in the same cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sef_bus_req_type;

  // link pin events already in the core clock domain
  typedef struct packed {
    logic clk_rise;
    logic clk_fall;
    logic tx_level;
  } sef_link_type;

endpackage : sef_pkg

/* logic/sef_link_sampler.sv */
// synchroniser and edge finder for the serial clock and transmit line pins
`timescale 1ns/1ps

module sef_link_sampler (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic tx_line_i,
  output sef_pkg::sef_link_type link_o
);

  // ----------------------------------------------------------------
  // two flops per pin, then one more stage for edge finding
  // ----------------------------------------------------------------
  logic [1:0] meta_r;   // first stage: read only by the second stage
  logic [1:0] sync_r;   // second stage: safe to use
  logic clk_prev_r;     // delayed serial clock for edge detection
  logic [1:0] meta_nxt;
  logic [1:0] sync_nxt;
  logic clk_prev_nxt;

  // next values of the sampling chain
  always_comb begin
    meta_nxt = {tx_line_i, link_clk_i};
    sync_nxt = meta_r;
    clk_prev_nxt = sync_r[0];
  end

  // register the chain; reset to idle low levels
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
      clk_prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  // edges are one core cycle pulses; clock and data share latency
  always_comb begin
    link_o.clk_rise = sync_r[0] & ~clk_prev_r;
    link_o.clk_fall = ~sync_r[0] & clk_prev_r;
    link_o.tx_level = sync_r[1];
  end

endmodule : sef_link_sampler

/* verification/sef_error_flags_assertions.sv */
// port level checker for the spi error flag block
`timescale 1ns/1ps

module sef_error_flags_assertions (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input sef_pkg::sef_bus_req_type req_i,
  input wire logic xfer_active_i,
  input wire logic xfer_done_i,
  input wire logic tx_bit_i,
  input wire logic link_clk_i,
  input wire logic tx_line_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic module_enable_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic rd_flags; // flag register read strobe
  logic quiet; // no transfer completion that could set overrun meanwhile
  assign rd_flags = req_i.rd && req_i.addr == 8'h10;
  assign quiet = !xfer_done_i;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rsvd_zero;
    rd_flags |=> rdata_o[31:7] == 25'h0 && !rdata_o[5] && rdata_o[3:0] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved flag bits not zero");
  property p_rd_clear;
    rd_flags && !xfer_active_i ##1 rd_flags && !xfer_active_i |=> !rdata_o[4];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("bit error flag survived a read");
  property p_w1c;
    req_i.wr && req_i.addr == 8'h10 && req_i.wdata[6] && quiet ##1 rd_flags && quiet
      |=> !rdata_o[6];
  endproperty
  a_w1c: assert property (p_w1c) else $error("overrun survived write one");
  property p_vec_clear;
    req_i.rd && (req_i.addr == 8'h60 || req_i.addr == 8'h64) && quiet ##1 rd_flags && quiet
      |=> !rdata_o[6];
  endproperty
  a_vec_clear: assert property (p_vec_clear) else $error("overrun survived vector read");
  property p_disable;
    req_i.wr && req_i.addr == 8'h04 && !req_i.wdata[0] && quiet ##1 rd_flags && quiet
      |=> !rdata_o[6] && !module_enable_o;
  endproperty
  a_disable: assert property (p_disable) else $error("overrun survived disable");
  property p_buf_keep;
    rd_flags && quiet ##1 req_i.rd && req_i.addr == 8'h40 && quiet ##1 rd_flags && quiet
      |=> rdata_o[6] == $past(rdata_o[6], 2);
  endproperty
  a_buf_keep: assert property (p_buf_keep) else $error("buffer read changed overrun");
  property p_wzero_keep;
    rd_flags && quiet ##1 req_i.wr && req_i.addr == 8'h10 && !req_i.wdata[6] && quiet
      ##1 rd_flags && quiet |=> rdata_o[6] == $past(rdata_o[6], 2);
  endproperty
  a_wzero_keep: assert property (p_wzero_keep) else $error("write zero changed overrun");
  // masks are the only path to the line, so all masked means quiet line
  property p_mask_irq;
    req_i.wr && req_i.addr == 8'h08 && !req_i.wdata[6] && !req_i.wdata[4] |-> ##2 !irq_o;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("interrupt while masked");
endmodule : sef_error_flags_assertions

bind sef_error_flags sef_error_flags_assertions i_sva (
  .core_clk_i(core_clk_i),
  .resetn_i(resetn_i),
  .req_i(req_i),
  .xfer_active_i(xfer_active_i),
  .xfer_done_i(xfer_done_i),
  .tx_bit_i(tx_bit_i),
  .link_clk_i(link_clk_i),
  .tx_line_i(tx_line_i),
  .rdata_o(rdata_o),
  .irq_o(irq_o),
  .module_enable_o(module_enable_o)
);

/* verification/sef_link_partner.sv */
// serial wire model: link clock, transmit line and frame level
`timescale 1ns/1ps

module sef_link_partner (
  input wire logic core_clk_i,
  output logic link_clk_o,
  output logic tx_line_o,
  output logic tx_bit_o,
  output logic xfer_active_o
);
  // clock idles high and stands still between frames
  initial begin
    link_clk_o = 1'b1;
    tx_line_o = 1'b0;
    tx_bit_o = 1'b0;
    xfer_active_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame, msb first; bad marks bits corrupted on the wire
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] bits, input logic [7:0] bad);
    @(posedge core_clk_i);
    xfer_active_o <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge core_clk_i);
      tx_bit_o <= bits[i];
      repeat (4) @(posedge core_clk_i);
      // pin edges off the core edge: the link has its own phase
      #3 link_clk_o = 1'b0;
      tx_line_o = bits[i] ^ bad[i];
      repeat (8) @(posedge core_clk_i);
      #3 link_clk_o = 1'b1; // receive point half a 160 ns period later
    end
    repeat (8) @(posedge core_clk_i);
    xfer_active_o <= 1'b0;
    tx_line_o = ~tx_line_o; // released line shows no stale level
  endtask : frame
endmodule : sef_link_partner

/* verification/sef_error_flags_tb.sv */
// self checking bench for the spi error flag block
`timescale 1ns/1ps

module sef_error_flags_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  sef_pkg::sef_bus_req_type req = '0;
  logic xfer_done = 1'b0;
  logic link_clk, tx_line, tx_bit, xfer_active, irq, mod_en;
  logic [31:0] rdata;
  logic [7:0] clr_addr [3] = '{8'h60, 8'h64, 8'h04}; // overrun clear paths
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 core_clk = ~core_clk;

  sef_error_flags i_dut (.core_clk_i(core_clk), .resetn_i(resetn), .req_i(req),
    .xfer_active_i(xfer_active), .xfer_done_i(xfer_done), .tx_bit_i(tx_bit),
    .link_clk_i(link_clk), .tx_line_i(tx_line), .rdata_o(rdata), .irq_o(irq),
    .module_enable_o(mod_en));
  sef_link_partner i_link (.core_clk_i(core_clk), .link_clk_o(link_clk),
    .tx_line_o(tx_line), .tx_bit_o(tx_bit), .xfer_active_o(xfer_active));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one bus cycle; on return rdata holds the answer to the previous read
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    #1;
  endtask : bus

  task automatic pulse();
    @(posedge core_clk);
    xfer_done <= 1'b1;
    @(posedge core_clk);
    xfer_done <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : pulse

  // drain the buffer, then two characters with no read between
  task automatic ovr();
    bus(1'b0, 1'b1, 8'h40, '0);
    bus(1'b0, 1'b0, 8'h00, '0);
    pulse();
    pulse();
  endtask : ovr

  task automatic do_reset();
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
  endtask : do_reset

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    bus(1'b0, 1'b1, 8'h10, '0);
    bus(1'b0, 1'b1, 8'h40, '0);
    chk("flags_reset", rdata, 32'h0);
    bus(1'b0, 1'b1, 8'h20, '0);
    chk("buffer_reset", rdata, 32'h0);
    bus(1'b1, 1'b0, 8'h04, 32'h1);
    chk("unmapped", rdata, 32'h0);
    bus(1'b1, 1'b0, 8'h08, 32'h50);
    ovr();
    bus(1'b0, 1'b1, 8'h10, '0);
    bus(1'b0, 1'b1, 8'h40, '0);
    chk("overrun_set", rdata, 32'h40);
    chk("irq_overrun", {31'h0, irq}, 32'h1);
    chk("enable", {31'h0, mod_en}, 32'h1);
    bus(1'b0, 1'b1, 8'h10, '0);
    chk("unread", rdata & 32'h8000_0000, 32'h8000_0000);
    bus(1'b1, 1'b0, 8'h10, 32'hffff_ffbf);
    chk("overrun_after_buffer_read", rdata, 32'h40);
    bus(1'b0, 1'b1, 8'h10, '0);
    bus(1'b1, 1'b0, 8'h10, 32'h40);
    chk("overrun_after_write_zero", rdata, 32'h40);
    bus(1'b0, 1'b1, 8'h10, '0);
    bus(1'b0, 1'b0, 8'h00, '0);
    chk("overrun_write_one", rdata, 32'h0);
    chk("irq_overrun_gone", {31'h0, irq}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ovr();
      bus(1'b0, 1'b1, 8'h10, '0);
      bus(i == 2, i != 2, clr_addr[i], '0);
      chk("overrun_again", rdata, 32'h40);
      bus(1'b0, 1'b1, 8'h10, '0);
      chk("vector", rdata & 32'h3, (i < 2) ? 32'h2 : 32'h0);
      bus(i == 2, 1'b0, 8'h04, 32'h1);
      chk("overrun_cleared", rdata, 32'h0);
    end
    ovr();
    do_reset();
    bus(1'b0, 1'b1, 8'h10, '0);
    bus(1'b1, 1'b0, 8'h04, 32'h1);
    chk("overrun_reset", rdata, 32'h0);
    bus(1'b1, 1'b0, 8'h08, 32'h50);
    bus(1'b0, 1'b0, 8'h00, '0); // drop the write strobe before the frame
    i_link.frame(8'ha5, 8'h00);
    bus(1'b0, 1'b1, 8'h10, '0);
    bus(1'b0, 1'b1, 8'h40, '0);
    chk("clean_frame", rdata, 32'h0);
    bus(1'b0, 1'b0, 8'h00, '0);
    chk("clean_buffer", rdata & 32'h1000, 32'h0);
    i_link.frame(8'h3c, 8'h08);
    bus(1'b0, 1'b0, 8'h00, '0);
    chk("irq_bit_error", {31'h0, irq}, 32'h1);
    bus(1'b0, 1'b1, 8'h10, '0);
    bus(1'b0, 1'b1, 8'h10, '0);
    chk("bit_error_set", rdata, 32'h10);
    bus(1'b0, 1'b1, 8'h40, '0);
    chk("bit_error_read_clear", rdata, 32'h0);
    bus(1'b1, 1'b0, 8'h08, 32'h0);
    chk("buffer_bit_error", rdata & 32'h1000, 32'h1000);
    bus(1'b0, 1'b0, 8'h00, '0); // drop the write strobe before the frame
    i_link.frame(8'hf0, 8'h81);
    bus(1'b0, 1'b1, 8'h10, '0);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b1, 1'b0, 8'h08, 32'h10);
    chk("bit_error_masked_flag", rdata, 32'h10);
    bus(1'b0, 1'b0, 8'h00, '0);
    bus(1'b0, 1'b0, 8'h00, '0);
    chk("irq_unmasked", {31'h0, irq}, 32'h1);
    bus(1'b0, 1'b1, 8'h40, '0);
    bus(1'b0, 1'b0, 8'h00, '0);
    bus(1'b0, 1'b0, 8'h00, '0);
    chk("irq_after_buffer_read", {31'h0, irq}, 32'h0);
    print_verdict();
  end
endmodule : sef_error_flags_tb
